// File: include/memory_page_mapper_consts.vh
// constants for the memory page mapper: data-space decode, register
// locations, field positions and widths
`ifndef MEMORY_PAGE_MAPPER_CONSTS_VH
`define MEMORY_PAGE_MAPPER_CONSTS_VH
`define DADDR_W 8
`define PADDR_W 13
`define PC_W 12
`define BANK_LO 8'h00
`define BANK_HI 8'h3f
`define WIN_LO 8'h40
`define WIN_HI 8'h7f
`define IDX_LO 8'h80
`define IDX_HI 8'h83
`define RAM_LO 8'h84
`define RAM_HI 8'hbf
`define PERI_LO 8'hc0
`define PERI_HI 8'hdf
`define LCD_LO 8'he0
`define LCD_HI 8'hf7
`define RAM2_LO 8'hf8
`define RAM2_HI 8'hfe
`define ACC_ADDR 8'hff
`define INT_OPT_ADDR 8'hc8
`define WIN_POS_ADDR 8'hc9
`define PAGE_SEL_ADDR 8'hca
`define BANK_SEL_ADDR 8'hcb
`define PAGE_BITS 2
`define WIN_BITS 6
`define WIN_OFS_BITS 6
`define BANK_NONE 8'h00
`define BANK_EE0 8'h01
`define BANK_EE1 8'h02
`define BANK_RAM1 8'h08
`define BANK_RAM2 8'h10
`define STATIC_PAGE 2'h1
`define PC_PAGE_BIT 11
`define STACK_DEPTH 6
`define SEL_NONE 4'h0
`define SEL_BANK 4'h1
`define SEL_WIN 4'h2
`define SEL_IDX 4'h3
`define SEL_RAM 4'h4
`define SEL_PERI 4'h5
`define SEL_LCD 4'h6
`define SEL_ACC 4'h7
`define SEL_WOREG 4'h8
`endif

// File: hw/return_stack.v
// six-level hardware stack of program-counter values
// assumes the core never pushes past the top nor pops an empty stack
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
  parameter WIDTH = 12,
  parameter DEPTH = 6
)
(
  input wire i_mclk,
  input wire i_rst,
  input wire i_push,
  input wire i_pop,
  input wire [WIDTH-1:0] i_data,
  output reg [WIDTH-1:0] o_top,
  output reg [3:0] o_level
);
  reg [WIDTH-1:0] level_mem [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : lvl
      wire [WIDTH-1:0] from_above;
      wire [WIDTH-1:0] from_below;
      // end levels pick their sources at elaboration, no stray indices
      if (g == 0)
      begin : head
        assign from_above = i_data;
      end
      else
      begin : inner
        assign from_above = level_mem[g-1];
      end
      if (g == DEPTH-1)
      begin : tail
        assign from_below = {WIDTH{1'b0}};
      end
      else
      begin : body
        assign from_below = level_mem[g+1];
      end
      always @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          level_mem[g] <= {WIDTH{1'b0}};
        else if (i_push)
          level_mem[g] <= from_above;
        else if (i_pop)
          level_mem[g] <= from_below;
      end
    end
  endgenerate
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_top <= {WIDTH{1'b0}};
      o_level <= 4'h0;
    end
    else if (i_push)
    begin
      o_top <= i_data;
      if (o_level != DEPTH[3:0])
        o_level <= o_level + 4'h1;
    end
    else if (i_pop)
    begin
      o_top <= level_mem[1];
      if (o_level != 4'h0)
        o_level <= o_level - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: hw/data_space_decoder.v
// combinational decode of the 256-location data space into regions
// assumes an 8-bit data address from the core
`timescale 1ns/1ps
`default_nettype none
`include "memory_page_mapper_consts.vh"
module data_space_decoder
(
  input wire [7:0] i_addr,
  output reg [3:0] o_sel
);
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction
  always @*
  begin
    o_sel = `SEL_NONE;
    if (in_range(i_addr, `BANK_LO, `BANK_HI))
      o_sel = `SEL_BANK;
    else if (in_range(i_addr, `WIN_LO, `WIN_HI))
      o_sel = `SEL_WIN;
    else if (in_range(i_addr, `IDX_LO, `IDX_HI))
      o_sel = `SEL_IDX;
    else if (in_range(i_addr, `RAM_LO, `RAM_HI))
      o_sel = `SEL_RAM;
    else if (in_range(i_addr, `INT_OPT_ADDR, `BANK_SEL_ADDR))
      o_sel = `SEL_WOREG;
    else if (in_range(i_addr, `PERI_LO, `PERI_HI))
      o_sel = `SEL_PERI;
    else if (in_range(i_addr, `LCD_LO, `LCD_HI))
      o_sel = `SEL_LCD;
    else if (in_range(i_addr, `RAM2_LO, `RAM2_HI))
      o_sel = `SEL_RAM;
    else if (i_addr == `ACC_ADDR)
      o_sel = `SEL_ACC;
  end
endmodule
`default_nettype wire

// File: hw/memory_page_mapper.v
// memory page mapper: program page select, data-space decode, read-only
// data window into program memory and the six-level return stack
// assumes the core presents one data access per cycle with a write strobe
// and a flag marking single-bit instructions; all inputs but the asynchronous reset i_rst are synchronous
//
// Overview of operation
// RULE1: page register at CAh, write-only, no bit ops
// RULE2: page register untouched by calls, returns, interrupts
// RULE3: only two page bits stored
// RULE4: PC bit 11 picks static page, else page
// RULE5: software writes page register before use
// RULE6: readout protection blocks external program reads
// RULE7: low data space decode up to BFh
// RULE8: peripheral, LCD, RAM and accumulator decode
// RULE9: C8h to CBh are write-only registers
// RULE10: four 64-byte banks overlay 00h-3Fh
// RULE11: six twelve-bit return address levels
// RULE12: window reads program memory, any aligned block; code forces address bit 12 to 0, so only blocks in 0000h-0FFFh
// RULE13: window address is position then six bits
// RULE14: window register at C9h holds six bits
// RULE15: software loads window register before use
// RULE16: window register write-only, no bit ops
// RULE17: software shadows registers rewritten in interrupts
// RULE18: 60 bytes general RAM unbanked
// RULE19: static page reachable two ways, same storage
// RULE20: bank register one-hot bank choice
// RULE21: reads of write-only registers change nothing
`timescale 1ns/1ps
`default_nettype none
`include "memory_page_mapper_consts.vh"
module memory_page_mapper #(
  parameter PC_W = 12,
  parameter PADDR_W = 13,
  parameter STACK_DEPTH = 6
)
(
  input wire i_mclk,
  input wire i_rst,
  input wire [PC_W-1:0] i_pc,
  input wire i_fetch,
  input wire i_call,
  input wire i_ret,
  input wire [7:0] i_daddr,
  input wire [7:0] i_dwdata,
  input wire i_dwr,
  input wire i_drd,
  input wire i_bit_op,
  input wire i_readout_protect,
  input wire i_ext_read,
  input wire [PADDR_W-1:0] i_ext_addr,
  output reg [PADDR_W-1:0] o_prog_addr,
  output reg o_prog_rd,
  output reg o_window_read,
  output reg o_ext_grant,
  output reg [3:0] o_region,
  output reg [7:0] o_bank_addr,
  output reg o_ram_bank1_sel,
  output reg o_ram_bank2_sel,
  output reg o_ee_bank0_sel,
  output reg o_ee_bank1_sel,
  output reg [7:0] o_int_option,
  output reg [1:0] o_page_number,
  output reg [5:0] o_window_position,
  output reg [7:0] o_bank_select,
  output reg [PC_W-1:0] o_ret_addr,
  output reg [3:0] o_stack_level
);
  wire [3:0] sel;
  wire [PC_W-1:0] stack_top;
  wire [3:0] stack_level;
  reg [1:0] page_number_bits;
  reg [5:0] window_position_bits;
  reg [7:0] ram_eeprom_bank_select;
  reg [7:0] int_option;
  reg [PADDR_W-1:0] next_prog_addr;
  reg next_prog_rd;
  reg next_window_read;
  reg next_ext_grant;
  wire wr_ok;

  data_space_decoder u_decode
  (
    .i_addr(i_daddr),
    .o_sel(sel)
  );

  // calls and interrupts only move the stack, never the mapping registers
  return_stack #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH)
  )
  u_stack
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_push(i_call),
    .i_pop(i_ret & ~i_call),
    .i_data(i_pc),
    .o_top(stack_top),
    .o_level(stack_level)
  ); // RULE11

  // single-bit instructions cannot reach the write-only registers
  assign wr_ok = i_dwr & ~i_bit_op; // RULE1 RULE16

  // write-only registers; reads leave them alone and return nothing
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      page_number_bits <= 2'h0;
      window_position_bits <= 6'h00;
      ram_eeprom_bank_select <= `BANK_NONE;
      int_option <= 8'h00;
    end
    else if (wr_ok) // RULE2 RULE21 RULE9
    begin
      case (i_daddr)
        `PAGE_SEL_ADDR:
          page_number_bits <= i_dwdata[`PAGE_BITS-1:0]; // RULE1 RULE3
        `WIN_POS_ADDR:
          window_position_bits <= i_dwdata[`WIN_BITS-1:0]; // RULE14
        `BANK_SEL_ADDR:
          ram_eeprom_bank_select <= i_dwdata; // RULE20
        `INT_OPT_ADDR:
          int_option <= i_dwdata;
        default:
          int_option <= int_option;
      endcase
    end
  end

  // program-side address: fetch, window read, or external readout
  always @*
  begin
    next_prog_addr = o_prog_addr;
    next_prog_rd = 1'b0;
    next_window_read = 1'b0;
    next_ext_grant = 1'b0;
    if (i_drd && sel == `SEL_WIN)
    begin
      next_prog_addr = {1'b0, window_position_bits,
        i_daddr[`WIN_OFS_BITS-1:0]}; // RULE12 RULE13
      next_prog_rd = 1'b1;
      next_window_read = 1'b1;
    end
    else if (i_fetch)
    begin
      if (i_pc[`PC_PAGE_BIT])
        next_prog_addr = {`STATIC_PAGE, i_pc[10:0]}; // RULE4 RULE19
      else
        next_prog_addr = {page_number_bits, i_pc[10:0]}; // RULE4
      next_prog_rd = 1'b1;
    end
    else if (i_ext_read && !i_readout_protect)
    begin
      next_prog_addr = i_ext_addr; // RULE6
      next_prog_rd = 1'b1;
      next_ext_grant = 1'b1;
    end
  end

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prog_addr <= {PADDR_W{1'b0}};
      o_prog_rd <= 1'b0;
      o_window_read <= 1'b0;
      o_ext_grant <= 1'b0;
      o_region <= `SEL_NONE;
      o_bank_addr <= 8'h00;
      o_ram_bank1_sel <= 1'b0;
      o_ram_bank2_sel <= 1'b0;
      o_ee_bank0_sel <= 1'b0;
      o_ee_bank1_sel <= 1'b0;
      o_int_option <= 8'h00;
      o_page_number <= 2'h0;
      o_window_position <= 6'h00;
      o_bank_select <= 8'h00;
      o_ret_addr <= {PC_W{1'b0}};
      o_stack_level <= 4'h0;
    end
    else
    begin
      o_prog_addr <= next_prog_addr;
      o_prog_rd <= next_prog_rd;
      o_window_read <= next_window_read;
      o_ext_grant <= next_ext_grant;
      o_region <= sel; // RULE7 RULE8 RULE18
      o_bank_addr <= {2'b00, i_daddr[5:0]}; // RULE10
      // a bank strobe only while the access falls in 00h-3Fh
      o_ee_bank0_sel <= (sel == `SEL_BANK) &
        ram_eeprom_bank_select[0]; // RULE10 RULE20
      o_ee_bank1_sel <= (sel == `SEL_BANK) & ram_eeprom_bank_select[1];
      o_ram_bank1_sel <= (sel == `SEL_BANK) & ram_eeprom_bank_select[3];
      o_ram_bank2_sel <= (sel == `SEL_BANK) & ram_eeprom_bank_select[4];
      o_int_option <= int_option;
      o_page_number <= page_number_bits;
      o_window_position <= window_position_bits;
      o_bank_select <= ram_eeprom_bank_select;
      o_ret_addr <= stack_top;
      o_stack_level <= stack_level;
    end
  end
endmodule
`default_nettype wire

// File: verif/mapper_props.sv
// assertions on the memory page mapper ports
// assumes one clock domain with asynchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "memory_page_mapper_consts.vh"
module mapper_props #(
  parameter PC_W = 12,
  parameter PADDR_W = 13
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic i_fetch,
  input wire logic i_call,
  input wire logic [7:0] i_daddr,
  input wire logic [7:0] i_dwdata,
  input wire logic i_dwr,
  input wire logic i_drd,
  input wire logic i_bit_op,
  input wire logic i_readout_protect,
  input wire logic [PADDR_W-1:0] o_prog_addr,
  input wire logic o_prog_rd,
  input wire logic o_window_read,
  input wire logic o_ext_grant,
  input wire logic [3:0] o_region,
  input wire logic [1:0] o_page_number,
  input wire logic [5:0] o_window_position,
  input wire logic [PC_W-1:0] o_ret_addr
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire win = i_drd && i_daddr >= `WIN_LO && i_daddr <= `WIN_HI;
  wire wr = i_dwr && !i_bit_op;
  a_win_addr: assert property (win |=> o_prog_rd && o_window_read &&
    o_prog_addr == {1'b0, o_window_position, $past(i_daddr[5:0])})
    else $error("window address wrong");
  a_fetch_addr: assert property (i_fetch && !win &&
    !(wr && i_daddr == `PAGE_SEL_ADDR) |=> o_prog_rd && !o_window_read &&
    o_prog_addr == {($past(i_pc[11]) ? `STATIC_PAGE : o_page_number),
    $past(i_pc[10:0])})
    else $error("fetch address wrong");
  a_page_write: assert property (wr && i_daddr == `PAGE_SEL_ADDR |->
    ##2 o_page_number == $past(i_dwdata[1:0], 2))
    else $error("page write lost");
  a_page_bitop: assert property (i_bit_op && i_dwr &&
    i_daddr == `PAGE_SEL_ADDR |-> ##2 $stable(o_page_number))
    else $error("bit write changed page");
  a_win_write: assert property (wr && i_daddr == `WIN_POS_ADDR |->
    ##2 o_window_position == $past(i_dwdata[5:0], 2))
    else $error("window write lost");
  a_region_win: assert property (i_daddr >= `WIN_LO &&
    i_daddr <= `WIN_HI |=> o_region == `SEL_WIN)
    else $error("window region wrong");
  a_region_wo: assert property (i_daddr >= `INT_OPT_ADDR &&
    i_daddr <= `BANK_SEL_ADDR |=> o_region == `SEL_WOREG)
    else $error("write-only region wrong");
  a_ext_block: assert property (i_readout_protect |=> !o_ext_grant)
    else $error("protected read granted");
  a_stack_push: assert property (i_call |=>
    ##1 o_ret_addr == $past(i_pc, 2))
    else $error("push not on top");
  c_win: cover property (win);
  c_static: cover property (i_fetch && i_pc[11]);
  c_call: cover property (i_call);
endmodule
bind memory_page_mapper mapper_props #(.PC_W(PC_W), .PADDR_W(PADDR_W))
  chk_u (.i_mclk, .i_rst, .i_pc, .i_fetch, .i_call, .i_daddr, .i_dwdata,
  .i_dwr, .i_drd, .i_bit_op, .i_readout_protect, .o_prog_addr, .o_prog_rd,
  .o_window_read, .o_ext_grant, .o_region, .o_page_number,
  .o_window_position, .o_ret_addr);
`default_nettype wire

// File: verif/core_model.sv
// core model: issues fetch, data and stack requests one at a time
// assumes the mapper takes requests on the rising edge
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input wire logic i_mclk,
  output logic [11:0] o_pc,
  output logic [7:0] o_daddr,
  output logic [7:0] o_dwdata,
  output logic [7:0] o_k
);
  initial
  begin
    o_k = 8'h00;
    o_pc = 12'h000;
    o_daddr = 8'h00;
    o_dwdata = 8'h00;
  end
  // strobes {protect,ext,ret,call,bitop,wr,rd,fetch}, held one cycle
  task go(input [7:0] k, input [11:0] pc, input [7:0] a, input [7:0] d);
    @(posedge i_mclk);
    #1;
    o_k = k;
    o_pc = pc;
    o_daddr = a;
    o_dwdata = d;
    @(posedge i_mclk);
    #1;
    o_k = 8'h00;
    o_dwdata = ~d;
  endtask
endmodule
`default_nettype wire

// File: verif/memory_page_mapper_bench.sv
// self-checking bench for the memory page mapper
// assumes the core model drives all requests
`timescale 1ns/1ps
`default_nettype none
`include "memory_page_mapper_consts.vh"
module memory_page_mapper_bench;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] i_pc, o_ret_addr;
  logic [7:0] i_daddr, i_dwdata, k, o_bank_addr, o_int_option, o_bank_select;
  logic [12:0] o_prog_addr;
  logic o_prog_rd, o_window_read, o_ext_grant;
  logic o_ram_bank1_sel, o_ram_bank2_sel, o_ee_bank0_sel, o_ee_bank1_sel;
  logic [3:0] o_region, o_stack_level;
  logic [1:0] o_page_number;
  logic [5:0] o_window_position;
  int fails = 0;
  int n_compared = 0;
  always #10 i_mclk = ~i_mclk;
  core_model core_u (.i_mclk, .o_pc(i_pc), .o_daddr(i_daddr),
    .o_dwdata(i_dwdata), .o_k(k));
  memory_page_mapper dut_u (.i_mclk, .i_rst, .i_pc, .i_daddr, .i_dwdata,
    .i_fetch(k[0]), .i_drd(k[1]), .i_dwr(k[2]), .i_bit_op(k[3]),
    .i_call(k[4]), .i_ret(k[5]), .i_ext_read(k[6]),
    .i_readout_protect(k[7]), .i_ext_addr({1'b0, i_pc}), .o_prog_addr,
    .o_prog_rd, .o_window_read, .o_ext_grant, .o_region, .o_bank_addr,
    .o_ram_bank1_sel, .o_ram_bank2_sel, .o_ee_bank0_sel, .o_ee_bank1_sel,
    .o_int_option, .o_page_number, .o_window_position, .o_bank_select,
    .o_ret_addr, .o_stack_level);
  task check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_region;
    logic [7:0] a[18] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'h83, 8'h84,
      8'hbf, 8'hc0, 8'hc8, 8'hcb, 8'hcc, 8'hdf, 8'he0, 8'hf7, 8'hf8, 8'hfe,
      8'hff};
    int s[18] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 8, 8, 5, 5, 6, 6, 4, 4, 7};
    foreach (a[i])
    begin
      core_u.go(8'h00, 12'h0, a[i], 8'h00);
      check(o_region, 16'(s[i]));
    end
  endtask
  task t_page;
    for (int p = 0; p < 4; p++)
    begin
      core_u.go(8'h04, 12'h0, `PAGE_SEL_ADDR, {6'h3f, 2'(p)});
      core_u.go(8'h01, 12'h123, 8'h00, 8'h00);
      check(o_prog_addr, {3'h0, 2'(p), 11'h123});
      check(o_page_number, 16'(p));
      core_u.go(8'h01, 12'h923, 8'h00, 8'h00);
      check(o_prog_addr, 16'h0923);
    end
  endtask
  task t_hold;
    core_u.go(8'h04, 12'h0, `PAGE_SEL_ADDR, 8'h02);
    core_u.go(8'h0c, 12'h0, `PAGE_SEL_ADDR, 8'h03);
    core_u.go(8'h02, 12'h0, `PAGE_SEL_ADDR, 8'h03);
    core_u.go(8'h01, 12'h5ab, 8'h00, 8'h00);
    check(o_prog_addr, 16'h15ab);
    for (int i = 1; i <= 6; i++)
    begin
      core_u.go(8'h10, 12'(i * 'h231), 8'h00, 8'h00);
      @(posedge i_mclk);
      #1;
      check(o_ret_addr, 16'(12'(i * 'h231)));
      check(o_stack_level, 16'(i));
    end
    for (int i = 5; i >= 0; i--)
    begin
      core_u.go(8'h20, 12'h0, 8'h00, 8'h00);
      @(posedge i_mclk);
      #1;
      check(o_stack_level, 16'(i));
      check(o_ret_addr, 16'(12'(i * 'h231)));
    end
    check(o_page_number, 16'h2);
  endtask
  task t_window;
    core_u.go(8'h04, 12'h0, `WIN_POS_ADDR, 8'hc5);
    core_u.go(8'h0c, 12'h0, `WIN_POS_ADDR, 8'h3f);
    core_u.go(8'h02, 12'h0, `WIN_POS_ADDR, 8'h3f);
    core_u.go(8'h02, 12'h0, 8'h43, 8'h00);
    check({o_window_read, o_prog_rd, o_prog_addr}, 16'h6143);
    core_u.go(8'h04, 12'h0, `WIN_POS_ADDR, 8'h3f);
    core_u.go(8'h03, 12'h123, 8'h7f, 8'h00);
    check({o_window_read, o_prog_rd, o_prog_addr}, 16'h6fff);
    check(o_window_position, 16'h3f);
  endtask
  task t_bank;
    logic [7:0] v[5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h10};
    foreach (v[i])
    begin
      core_u.go(8'h04, 12'h0, `BANK_SEL_ADDR, v[i]);
      core_u.go(8'h02, 12'h0, 8'h25, 8'h00);
      check(o_bank_select, v[i]);
      check({o_ram_bank2_sel, o_ram_bank1_sel, o_ee_bank1_sel,
        o_ee_bank0_sel}, {v[i][4:3], v[i][1:0]});
      check(o_bank_addr, 16'h25);
    end
    core_u.go(8'h04, 12'h0, `INT_OPT_ADDR, 8'ha5);
    core_u.go(8'h0c, 12'h0, `INT_OPT_ADDR, 8'h5a);
    check(o_int_option, 16'ha5);
  endtask
  task t_ext;
    core_u.go(8'h40, 12'h155, 8'h00, 8'h00);
    check({o_ext_grant, o_prog_addr}, 16'h2155);
    core_u.go(8'hc0, 12'h155, 8'h00, 8'h00);
    check(o_ext_grant, 16'h0);
  endtask
  initial
  begin
    repeat (8) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    t_region;
    t_page;
    t_hold;
    t_window;
    t_bank;
    t_ext;
    end_of_test;
  end
  initial
  begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
